// ===== ptb_pkg.sv
// package: register map, fields and state of the periodic timebase counter
package ptb_pkg;

  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [5:0] COUNT_VALUE_IDX = 6'h36;
  localparam logic [5:0] CTRL_STATUS_IDX = 6'h37;

  // ==========================================================
  // control/status field positions
  localparam int PSEL_LSB = 0;
  localparam int RUN_BIT = 3;
  localparam int RIE_BIT = 4;
  localparam int ROLL_BIT = 5;

  // ==========================================================
  // reset values and counter maximum
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ==========================================================
  // control/status layout as read back
  typedef struct packed {
    logic [1:0] rsvd;
    logic roll;
    logic rie;
    logic run;
    logic [2:0] psel;
  } ptb_csr_t;

  // ==========================================================
  // whole module state
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] presc;
    logic roll;
    logic rie;
    logic run;
    logic [2:0] psel;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } ptb_state_t;

endpackage

// ===== ptb_timebase.sv
// periodic timebase counter with a classic wishbone register slave
// ==========================================================
// Functional notes
// - A free-running 8-bit up-counter that never reloads or stops on wrap.
// - Setting run-enable resumes counting from the held value, not zero.
// - The counter advances by one on each tick of the selected prescaler.
// - A wrap from ff to 00 sets the rollover flag whatever the enable.
// - The interrupt request is high while rollover flag and enable are set.
// - Software may write the counter anytime; counting goes on from it.
// - Only hardware sets the flag; a status read clears it, writes do not.
// - With run-enable low the counter holds and the prescaler is in reset.
// - A 3-bit prescale select picks power-of-two division from 2 to 256.
// - Reset clears the counter and every control/status bit to zero.
`timescale 1ns/1ps
module ptb_timebase (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // power mode and interrupt
  input wire logic halt_mode,
  output logic irq
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // state
  ptb_pkg::ptb_state_t s_r;
  ptb_pkg::ptb_state_t s_nxt;
  ptb_pkg::ptb_state_t s_rst;

  logic acc;
  logic wr_cnt;
  logic wr_csr;
  logic rd_csr;
  logic active;
  logic [7:0] tick_mask;
  logic tick;
  logic wrap;
  ptb_pkg::ptb_csr_t csr_view;

  always_comb begin
    s_rst = '0;
    s_rst.cnt = ptb_pkg::COUNT_RST;
    s_rst.presc = ptb_pkg::PRESC_RST;
    s_rst.roll = ptb_pkg::CTRL_RST[ptb_pkg::ROLL_BIT];
    s_rst.rie = ptb_pkg::CTRL_RST[ptb_pkg::RIE_BIT];
    s_rst.run = ptb_pkg::CTRL_RST[ptb_pkg::RUN_BIT];
    s_rst.psel = ptb_pkg::CTRL_RST[ptb_pkg::PSEL_LSB +: 3];
  end

  // ==========================================================
  // bus decode: one access per request, ack one cycle later
  assign acc = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr_cnt = acc && wb_we_i && wb_sel_i[0] &&
                  (wb_adr_i[7:2] == ptb_pkg::COUNT_VALUE_IDX);
  assign wr_csr = acc && wb_we_i && wb_sel_i[0] &&
                  (wb_adr_i[7:2] == ptb_pkg::CTRL_STATUS_IDX);
  assign rd_csr = acc && !wb_we_i &&
                  (wb_adr_i[7:2] == ptb_pkg::CTRL_STATUS_IDX);

  // ==========================================================
  // prescaler and tick
  // halt stops counting and clears the prescaler, bus writes still land
  assign active = s_r.run && !halt_mode;
  // code n divides by 2^(n+1): low n+1 bits all ones
  assign tick_mask = 8'hff >> (3'h7 - s_r.psel);
  assign tick = active && ((s_r.presc & tick_mask) == tick_mask);
  assign wrap = tick && !wr_cnt && (s_r.cnt == ptb_pkg::COUNT_MAX);

  always_comb begin
    csr_view = '0;
    csr_view.roll = s_r.roll;
    csr_view.rie = s_r.rie;
    csr_view.run = s_r.run;
    csr_view.psel = s_r.psel;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = acc;
    // prescaler held in reset while stopped
    if (active) begin
      s_nxt.presc = s_r.presc + 8'h01;
    end else begin
      s_nxt.presc = ptb_pkg::PRESC_RST;
    end
    // software write beats the increment so the written value sticks
    if (wr_cnt) begin
      s_nxt.cnt = wb_dat_i[7:0];
    end else if (tick) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
    if (wr_csr) begin
      s_nxt.rie = wb_dat_i[ptb_pkg::RIE_BIT];
      s_nxt.run = wb_dat_i[ptb_pkg::RUN_BIT];
      s_nxt.psel = wb_dat_i[ptb_pkg::PSEL_LSB +: 3];
    end
    // set wins over the read clear so no wrap is lost
    if (wrap) begin
      s_nxt.roll = 1'b1;
    end else if (rd_csr) begin
      s_nxt.roll = 1'b0;
    end
    s_nxt.dat = '0;
    if (acc && !wb_we_i) begin
      case (wb_adr_i[7:2])
        ptb_pkg::COUNT_VALUE_IDX: s_nxt.dat = {24'h000000, s_r.cnt};
        ptb_pkg::CTRL_STATUS_IDX: s_nxt.dat = {24'h000000, csr_view};
        default: s_nxt.dat = '0;
      endcase
    end
    s_nxt.irq = s_nxt.roll && s_nxt.rie;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign irq = s_r.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_reset_clear;
    $rose(rst_n) |-> (s_r == s_rst);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared at reset release");

  property p_wrap_zero;
    wrap |=> (s_r.cnt == 8'h00);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("counter did not wrap to zero");

  property p_inc;
    tick && !wr_cnt |=> s_r.cnt == $past(s_r.cnt) + 8'h01;
  endproperty
  a_inc: assert property (p_inc)
    else $error("counter did not advance on tick");

  property p_start_hold;
    $rose(s_r.run) && !halt_mode && !wr_cnt |->
      s_r.cnt == $past(s_r.cnt);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("counter jumped when started");

  property p_roll_set;
    wrap |=> s_r.roll ##1 (s_r.roll || $past(rd_csr));
  endproperty
  a_roll_set: assert property (p_roll_set)
    else $error("rollover flag not set on wrap");

  property p_irq;
    irq == (s_r.roll && s_r.rie);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow flag and enable");

  property p_write_cnt;
    wr_cnt |=> s_r.cnt == $past(wb_dat_i[7:0]);
  endproperty
  a_write_cnt: assert property (p_write_cnt)
    else $error("counter write not taken");

  property p_roll_read;
    rd_csr && !wrap |=> !s_r.roll;
  endproperty
  a_roll_read: assert property (p_roll_read)
    else $error("status read did not clear flag");

  property p_roll_only_hw;
    !s_r.roll && !wrap |=> !s_r.roll;
  endproperty
  a_roll_only_hw: assert property (p_roll_only_hw)
    else $error("rollover flag set without wrap");

  property p_stopped;
    (!s_r.run || halt_mode) && !wr_cnt |=>
      s_r.presc == 8'h00 && $stable(s_r.cnt);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped or halted");

  property p_div2;
    tick && s_r.psel == 3'h0 |=> !tick;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide-by-two ticks back to back");

  property p_div256;
    tick && s_r.psel == 3'h7 |-> s_r.presc == 8'hff;
  endproperty
  a_div256: assert property (p_div256)
    else $error("divide-by-256 tick at wrong count");

  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered in one cycle");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");

  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside an answer");

  property p_dat_upper;
    wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_upper: assert property (p_dat_upper)
    else $error("upper read data bits not zero");

  property p_csr_rsvd;
    rd_csr |=> wb_dat_o[7:6] == 2'b00;
  endproperty
  a_csr_rsvd: assert property (p_csr_rsvd)
    else $error("reserved status bits not zero");

  property p_presc_run;
    active |=> s_r.presc == $past(s_r.presc) + 8'h01;
  endproperty
  a_presc_run: assert property (p_presc_run)
    else $error("prescaler not running while enabled");

  property p_halt_presc;
    halt_mode |=> s_r.presc == 8'h00;
  endproperty
  a_halt_presc: assert property (p_halt_presc)
    else $error("prescaler not cleared in halt");

  property p_cnt_only;
    !tick && !wr_cnt |=> $stable(s_r.cnt);
  endproperty
  a_cnt_only: assert property (p_cnt_only)
    else $error("counter moved without tick or write");

  property p_flag_write;
    wr_csr && !wrap |=> s_r.roll == $past(s_r.roll);
  endproperty
  a_flag_write: assert property (p_flag_write)
    else $error("status write changed the rollover flag");

  property p_irq_rise;
    wrap && s_r.rie && !wr_csr |=> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt not raised on enabled wrap");

  property p_div8;
    tick && s_r.psel == 3'h2 |-> s_r.presc[2:0] == 3'h7;
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide-by-eight tick at wrong count");

  property p_csr_run;
    wr_csr |=> s_r.run == $past(wb_dat_i[ptb_pkg::RUN_BIT]);
  endproperty
  a_csr_run: assert property (p_csr_run)
    else $error("run enable write not taken");

  property p_reset_out;
    $rose(rst_n) |-> !wb_ack_o && !irq && wb_dat_o == 32'h00000000;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle at reset release");

  c_wrap: cover property (wrap && s_r.rie);
  c_read_clear: cover property (s_r.roll && rd_csr);
  c_write_run: cover property (wr_cnt && tick);
  c_halt: cover property (s_r.run && halt_mode);
  c_div256: cover property (tick && s_r.psel == 3'h7);

endmodule

// ===== tb_top.sv
// testbench: self-checking run of the periodic timebase counter
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // signals
  logic ref_clk, rstn, cyc, stb, we, halt_mode, ack, irq, ie_b;
  logic [7:0] adr, st;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int err_count = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int t_ack, t0, len, ticks, exp_c;
  int mq[$];
  localparam logic [7:0] A_CNT = {ptb_pkg::COUNT_VALUE_IDX, 2'b00};
  localparam logic [7:0] A_CSR = {ptb_pkg::CTRL_STATUS_IDX, 2'b00};

  ptb_timebase DUT (
    .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .halt_mode(halt_mode), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc_n <= cyc_n + 1;

  // ==========================================================
  // reporting
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_dat(input logic [31:0] g, input logic [31:0] e,
                         input string w);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic chk_irq(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t irq got %b exp %b", $time, g, e);
    end
  endtask

  // ==========================================================
  // classic wishbone cycle; ack and read data taken at one rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    t_ack = cyc_n;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED t=%0t no ack", $time);
      summarize();
    end else begin
      @(posedge ref_clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string w);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_dat(q, e, w);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h00000000; halt_mode = 1'b0; rstn = 1'b0;
    void'($urandom(33059));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(A_CNT, 32'h00000000, "count reset");
    rd(A_CSR, 32'h00000000, "csr reset");
    chk_irq(irq, 1'b0);
    $display("test reset done");
    // flag bit must not take a written one; reserved bits kept zero
    wr(A_CSR, 8'h27);
    rd(A_CSR, 32'h00000007, "csr write mask");
    wr(8'h00, 8'h5a);
    rd(8'h00, 32'h00000000, "unmapped");
    rd(A_CNT, 32'h00000000, "count kept");
    $display("test masks done");
    // every prescale code, random start, length and enable
    for (int p = 0; p < 8; p++) begin
      st = 8'($urandom_range(255, 200));
      ie_b = 1'($urandom_range(1, 0));
      len = $urandom_range(600, 40);
      wr(A_CNT, st);
      wr(A_CSR, {3'b000, ie_b, 1'b1, p[2:0]});
      t0 = t_ack;
      repeat (len) @(posedge ref_clk);
      wr(A_CSR, {3'b000, ie_b, 1'b0, p[2:0]});
      // stop edge still counts; prescaler restarts at zero each run
      ticks = (t_ack - t0) >> (p + 1);
      exp_c = int'(st) + ticks;
      mq.push_back(exp_c & 255);
      chk_irq(irq, (exp_c > 255) & ie_b);
      rd(A_CNT, 32'(mq[0]), "count");
      rd(A_CSR, {26'h0, exp_c > 255, ie_b, 1'b0, p[2:0]}, "flag");
      rd(A_CSR, {27'h0, ie_b, 1'b0, p[2:0]}, "flag cleared");
      chk_irq(irq, 1'b0);
      rd(A_CNT, 32'(mq.pop_front()), "count frozen");
    end
    $display("test prescale done");
    // count write lands on a tick edge: the written value must win
    wr(A_CNT, 8'h10);
    wr(A_CSR, 8'h08);
    t0 = t_ack;
    @(posedge ref_clk);
    st = 8'($urandom_range(200, 0));
    wr(A_CNT, st);
    ticks = -((t_ack - t0) >> 1);
    repeat ($urandom_range(40, 10)) @(posedge ref_clk);
    wr(A_CSR, 8'h00);
    ticks += (t_ack - t0) >> 1;
    rd(A_CNT, 32'(int'(st) + ticks), "count write");
    rd(A_CSR, 32'h00000000, "no flag");
    $display("test write done");
    // halted while enabled: written value must stay put
    wr(A_CSR, 8'h08);
    halt_mode <= 1'b1;
    wr(A_CNT, 8'h33);
    repeat (20) @(posedge ref_clk);
    rd(A_CNT, 32'h00000033, "halted");
    halt_mode <= 1'b0;
    wr(A_CSR, 8'h00);
    $display("test halt done");
    summarize();
  end
endmodule
